// ### hdl/pport_map.svh
/*
  Register indices, field positions, reset values and timing counts of the
  parallel data port. Assumes a 200 MHz bus clock; a register's byte
  address on the bus is four times its index.
*/
`ifndef PPORT_MAP_SVH
`define PPORT_MAP_SVH
// How it works
// [RULE_01] Byte transfers move one byte each; multi-byte values go most significant byte first.
// [RULE_02] A byte output uses the low eight output lines; the upper eight carry zero.
// [RULE_03] A byte input takes only the low eight input lines; upper lines are ignored.
// [RULE_04] Word transfers use all sixteen lines; input words read as signed integers.
// [RULE_05] Writing data-output word register 3 updates lines directly, with no handshake.
// [RULE_06] That write changes only the sixteen output lines and the direction line.
// [RULE_07] Reading data-input word register 3 drives direction High and returns the inputs.
// [RULE_08] Each data line level follows a selectable polarity, low-true or high-true.
// [RULE_09] Control register 2: bit 0 drives aux output zero Low, bit 1 aux one.
// [RULE_10] A cleared aux bit drives its line High; this polarity is fixed.
// [RULE_11] Aux outputs hold until control register 2 is rewritten; interface reset keeps them.
// [RULE_12] Status register 5 bits 0 and 1 read 1 when aux inputs are Low.
// [RULE_13] Aux input to status bit mapping is fixed; 0 means the line is High.
// [RULE_14] Status bit 3 is status OK, bit 2 interrupt line Low, bits 7-4 zero.
// [RULE_15] Status bits show live line states at the read, never latched by events.
// [RULE_16] Output transfers drive direction Low with data present; input transfers drive it High. A coinciding read wins; a sequence's low byte keeps it.
// [RULE_17] Aux inputs and status lines pass a two-stage synchronizer before being reported.

// ---------------------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------------------
`define IDX_IF_RESET     6'h00
`define IDX_PCTRL        6'h02
`define IDX_DATA_WORD    6'h03
`define IDX_PSTATUS      6'h05
`define IDX_DATA_BYTE    6'h06
`define IDX_BYTE_SEQ     6'h07
`define IDX_CONFIG       6'h08

// ---------------------------------------------------------------------------
// Field positions and reset values
// ---------------------------------------------------------------------------
`define PCTRL_AUX0_BIT   0
`define PCTRL_AUX1_BIT   1
`define CFG_LOW_TRUE_BIT 0
`define CFG_SEQ_BUSY_BIT 1
`define PCTRL_RESET      2'h0
`define CONFIG_RESET     1'h0

// ---------------------------------------------------------------------------
// Timing
// ---------------------------------------------------------------------------
`define CLK_PERIOD_PS    5000
`define BYTE_HOLD_NS     100
`define BYTE_HOLD_CYC    ((`BYTE_HOLD_NS * 1000) / `CLK_PERIOD_PS)
`endif

// ### hdl/pport_pkg.sv
/*
  Types shared by the parallel data port: pin groups and the latched bus
  command. Assumes nothing beyond the companion map header.
*/
package pport_pkg;
  typedef struct packed {
    logic [15:0] data_in;
    logic [1:0]  aux_in;
    logic        status_ok;
    logic        ext_irq;
  } line_in_t;

  typedef struct packed {
    logic [15:0] data_out;
    logic        dir;
    logic [1:0]  aux_out;
  } line_out_t;

  typedef struct packed {
    logic       wr;
    logic [5:0] idx;
  } bus_cmd_t;

  typedef enum logic {
    SEQ_IDLE = 1'b0,
    SEQ_LSB  = 1'b1
  } seq_state_t;
endpackage

// ### hdl/pport_top.sv
/*
  Parallel data port with AHB-Lite register access: word and byte data
  paths, direction line, two auxiliary outputs and live peripheral status.
  Assumes one 200 MHz clock, pins sampled through local synchronizers and
  a single AHB-Lite master issuing whole-word single transfers.
*/
`timescale 1ns/1ps
`include "pport_map.svh"

module pport_top
  import pport_pkg::*;
#(
  parameter int unsigned BYTE_HOLD = `BYTE_HOLD_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire line_in_t    pins_in,
  output line_out_t        pins_out
);

  localparam int CW = $clog2(BYTE_HOLD + 1);

  // ---------------------------------------------------------------------------
  // Input synchronizers
  // ---------------------------------------------------------------------------
  line_in_t meta_r;
  line_in_t sync_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= pins_in;  // [RULE_17]
      sync_r <= meta_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Address phase decode
  // ---------------------------------------------------------------------------
  bus_cmd_t   dph_r;
  logic       dph_vld_r;
  logic       low_true_r;
  logic       low_true_nxt;
  logic [1:0] pctrl_r;
  logic [1:0] pctrl_nxt;
  logic [15:0] dout_r;
  logic [15:0] dout_nxt;
  logic        dir_r;
  logic        dir_nxt;
  seq_state_t  seq_r;
  seq_state_t  seq_nxt;
  logic [7:0]  lsb_r;
  logic [7:0]  lsb_nxt;
  logic [CW-1:0] hold_r;
  logic [CW-1:0] hold_nxt;
  logic [31:0] hrdata_r;
  logic        hreadyout_r;
  logic        hresp_r;
  line_out_t   pins_out_r;

  wire logic       a_take = hsel & htrans[1] & hready;
  wire logic       a_map  = (haddr[31:8] == 24'h000000);
  wire logic [5:0] a_idx  = haddr[7:2];
  wire logic       a_rd   = a_take & ~hwrite & a_map;
  wire logic       a_wr   = a_take & hwrite & a_map;

  wire logic rd_word = a_rd & (a_idx == `IDX_DATA_WORD);
  wire logic rd_byte = a_rd & (a_idx == `IDX_DATA_BYTE);
  wire logic rd_stat = a_rd & (a_idx == `IDX_PSTATUS);
  wire logic rd_cfg  = a_rd & (a_idx == `IDX_CONFIG);

  // ---------------------------------------------------------------------------
  // Read data, taken at the address-phase edge
  // ---------------------------------------------------------------------------
  // Status is built from the synchronized pins each cycle, so a read shows
  // the lines as they stand, never a captured event.
  wire logic [7:0] stat_byte = {4'h0,                // [RULE_14]
                                sync_r.status_ok,    // [RULE_14]
                                ~sync_r.ext_irq,     // [RULE_14]
                                ~sync_r.aux_in[1],   // [RULE_12] [RULE_13]
                                ~sync_r.aux_in[0]};  // [RULE_12] [RULE_13] [RULE_15]

  wire logic [15:0] din_logic = sync_r.data_in ^ {16{low_true_r}};  // [RULE_08]

  wire logic [31:0] rd_mux =
      rd_word ? {{16{din_logic[15]}}, din_logic} :  // [RULE_04] [RULE_07]
      rd_byte ? {24'h000000, din_logic[7:0]} :      // [RULE_03]
      rd_stat ? {24'h000000, stat_byte} :           // [RULE_15]
      rd_cfg  ? {30'h00000000, (seq_r == SEQ_LSB), low_true_r} :
                32'h00000000;

  // ---------------------------------------------------------------------------
  // Data phase writes
  // ---------------------------------------------------------------------------
  wire logic d_wr    = dph_vld_r & dph_r.wr;
  wire logic wr_rst  = d_wr & (dph_r.idx == `IDX_IF_RESET);
  wire logic wr_pctl = d_wr & (dph_r.idx == `IDX_PCTRL);
  wire logic wr_word = d_wr & (dph_r.idx == `IDX_DATA_WORD);
  wire logic wr_byte = d_wr & (dph_r.idx == `IDX_DATA_BYTE);
  wire logic wr_seq  = d_wr & (dph_r.idx == `IDX_BYTE_SEQ);
  wire logic wr_cfg  = d_wr & (dph_r.idx == `IDX_CONFIG);
  wire logic wr_out  = wr_word | wr_byte | wr_seq;

  // Second byte of a sequence goes out once the first has been held long
  // enough; a new data write abandons the pending byte.
  wire logic seq_due = (seq_r == SEQ_LSB) & (hold_r == '0) & ~wr_out & ~wr_rst;

  // Interface reset leaves aux outputs, direction and the data value untouched, but restores high-true polarity.
  assign low_true_nxt = wr_rst ? `CONFIG_RESET :
                        wr_cfg ? hwdata[`CFG_LOW_TRUE_BIT] : low_true_r;

  assign pctrl_nxt = wr_pctl ? {hwdata[`PCTRL_AUX1_BIT], hwdata[`PCTRL_AUX0_BIT]}  // [RULE_09] [RULE_11]
                             : pctrl_r;

  assign dout_nxt = wr_word ? hwdata[15:0] :            // [RULE_04] [RULE_05]
                    wr_byte ? {8'h00, hwdata[7:0]} :    // [RULE_02]
                    wr_seq  ? {8'h00, hwdata[15:8]} :   // [RULE_01] [RULE_02]
                    seq_due ? {8'h00, lsb_r} :          // [RULE_01]
                              dout_r;

  // A read in its address phase wins over a write finishing its data phase.
  assign dir_nxt = (rd_word | rd_byte) ? 1'b1 :  // [RULE_07] [RULE_16]
                   wr_out              ? 1'b0 :  // [RULE_06] [RULE_16]
                                         dir_r;

  assign seq_nxt = wr_seq                       ? SEQ_LSB :
                   (wr_out | wr_rst | seq_due)  ? SEQ_IDLE :
                                                  seq_r;

  assign lsb_nxt  = wr_seq ? hwdata[7:0] : lsb_r;
  assign hold_nxt = wr_seq ? CW'(BYTE_HOLD - 1) :
                    (hold_r != '0) ? hold_r - CW'(1) : hold_r;

  // ---------------------------------------------------------------------------
  // Bus pipeline and response
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_vld_r   <= 1'b0;
      dph_r       <= '0;
      hrdata_r    <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      dph_vld_r   <= a_wr;
      dph_r       <= '{wr: a_wr, idx: a_idx};
      hrdata_r    <= rd_mux;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Port state
  // ---------------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_true_r <= `CONFIG_RESET;
      pctrl_r    <= `PCTRL_RESET;
      dout_r     <= 16'h0000;
      dir_r      <= 1'b0;
      seq_r      <= SEQ_IDLE;
      lsb_r      <= 8'h00;
      hold_r     <= '0;
    end else begin
      low_true_r <= low_true_nxt;
      pctrl_r    <= pctrl_nxt;
      dout_r     <= dout_nxt;
      dir_r      <= dir_nxt;
      seq_r      <= seq_nxt;
      lsb_r      <= lsb_nxt;
      hold_r     <= hold_nxt;
    end
  end

  // Pin levels are registered from the next-state values so the lines move
  // in the same cycle as the logical state.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pins_out_r <= '{data_out: 16'h0000, dir: 1'b0, aux_out: 2'h3};
    end else begin
      pins_out_r.data_out <= dout_nxt ^ {16{low_true_nxt}};  // [RULE_08]
      pins_out_r.dir      <= dir_nxt;                        // [RULE_16]
      pins_out_r.aux_out  <= ~pctrl_nxt;                     // [RULE_10]
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;
  assign pins_out  = pins_out_r;

  // ---------------------------------------------------------------------------
  // Assertion helpers
  // ---------------------------------------------------------------------------
  // Age of the pending byte sequence, kept apart from the hold counter so the
  // low-byte timing is checked against an independent count. It saturates at
  // the hold time, so long idle stretches never wrap it.
  logic [CW-1:0] seq_age_r;
  logic [CW-1:0] seq_age_nxt;

  assign seq_age_nxt = wr_seq                        ? CW'(1) :
                       (seq_age_r != CW'(BYTE_HOLD)) ? seq_age_r + CW'(1) :
                                                       seq_age_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seq_age_r <= '0;
    end else begin
      seq_age_r <= seq_age_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence seq_start_s;
    wr_seq && !wr_rst;
  endsequence

  sequence seq_msb_out_s;
    ##1 (pins_out.data_out == ({8'h00, $past(hwdata[15:8])} ^ {16{low_true_r}}));
  endsequence

  chk_byte_msb_first: assert property (seq_start_s |-> seq_msb_out_s)  // [RULE_01]
    else $error("sequenced word did not put its high byte out first");

  chk_byte_lsb_next: assert property (seq_due |=>  // [RULE_01]
      pins_out.data_out[7:0] == ($past(lsb_r) ^ {8{low_true_r}}))
    else $error("pending low byte did not follow the high byte");

  chk_byte_upper_zero: assert property (wr_byte |=>  // [RULE_02]
      pins_out.data_out[15:8] == {8{low_true_r}})
    else $error("byte output left the upper lines non-zero");

  chk_byte_in_low: assert property (rd_byte |=>  // [RULE_03]
      hrdata_r == {24'h000000, $past(din_logic[7:0])})
    else $error("byte read did not return only the low input byte");

  chk_word_signed: assert property (rd_word |=>  // [RULE_04]
      hrdata_r == {{16{$past(din_logic[15])}}, $past(din_logic)})
    else $error("word read not sign extended from the input lines");

  chk_word_out_direct: assert property (wr_word && !rd_word && !rd_byte |=>  // [RULE_05]
      pins_out.data_out == ($past(hwdata[15:0]) ^ {16{low_true_r}}) && !pins_out.dir
      && $stable(pins_out.aux_out))  // [RULE_06]
    else $error("word write did not reach the output lines alone");

  chk_read_dir_high: assert property (rd_word || rd_byte |=> pins_out.dir)  // [RULE_07]
    else $error("input read did not drive the direction line high");

  chk_out_dir_low: assert property (wr_out && !rd_word && !rd_byte |=> !pins_out.dir)  // [RULE_16]
    else $error("output write did not drive the direction line low");

  chk_line_polarity: assert property (pins_out.data_out == (dout_r ^ {16{low_true_r}}))  // [RULE_08]
    else $error("data line level disagrees with the selected polarity");

  chk_aux_fixed_sense: assert property (pins_out.aux_out == ~pctrl_r)  // [RULE_09] [RULE_10]
    else $error("aux output level does not match its control bit");

  chk_aux_hold_level: assert property (!wr_pctl |=> $stable(pins_out.aux_out))  // [RULE_11]
    else $error("aux output changed without a control write");

  chk_status_live: assert property (rd_stat |=>  // [RULE_12] [RULE_13] [RULE_14]
      hrdata_r == {24'h000000, 4'h0, $past(sync_r.status_ok), ~$past(sync_r.ext_irq),
                   ~$past(sync_r.aux_in)})  // [RULE_15]
    else $error("status read does not reflect the current line states");

  chk_sync_depth: assert property (##2 (sync_r == $past(pins_in, 2)))  // [RULE_17]
    else $error("synchronizer is not two stages deep");

  // ---------------------------------------------------------------------------
  // Side effects, timing and decode
  // ---------------------------------------------------------------------------
  // A pending low byte must wait out the full hold time, never go out early.
  chk_lsb_on_time: assert property (seq_due |-> seq_age_r == CW'(BYTE_HOLD))  // [RULE_01]
    else $error("pending low byte did not wait the hold time");

  // A new data write or interface reset drops the pending byte instead of
  // sending it late over the top of the newer value.
  chk_seq_cancel: assert property ((seq_r == SEQ_LSB) && (wr_out || wr_rst) && !wr_seq |=>  // [RULE_01]
      seq_r == SEQ_IDLE)
    else $error("data write or interface reset left a byte pending");

  chk_seq_upper_zero: assert property ((seq_r == SEQ_LSB) |-> dout_r[15:8] == 8'h00)  // [RULE_02]
    else $error("byte sequence left the upper output byte non-zero");

  // Reads move only the direction line; no handshake and no data change.
  chk_read_no_data: assert property ((rd_word || rd_byte) && !d_wr && !seq_due |=>  // [RULE_07]
      $stable(pins_out.data_out) && $stable(pins_out.aux_out))
    else $error("input read disturbed the output lines");

  chk_data_lines_quiet: assert property (!d_wr && !seq_due |=> $stable(pins_out.data_out))  // [RULE_06]
    else $error("data lines moved without a write or sequence step");

  // The direction line moves only with a data transfer.
  chk_dir_lines_quiet: assert property (!wr_out && !rd_word && !rd_byte |=>  // [RULE_06] [RULE_16]
      $stable(pins_out.dir))
    else $error("direction line moved without a data transfer");

  chk_pctl_only_aux: assert property (wr_pctl && !rd_word && !rd_byte && !seq_due |=>  // [RULE_09]
      $stable(pins_out.data_out) && $stable(pins_out.dir) && pins_out.aux_out == ~$past(hwdata[1:0]))
    else $error("control write changed more than the aux outputs");

  chk_ifreset_keeps: assert property (wr_rst && !rd_word && !rd_byte |=>  // [RULE_11]
      $stable(pins_out.aux_out) && $stable(pins_out.dir) && $stable(dout_r))
    else $error("interface reset disturbed the aux, direction or data state");

  // Unused status bits stay zero whatever the lines do.
  chk_status_upper: assert property (rd_stat |=> hrdata_r[31:4] == 28'h0000000)  // [RULE_14]
    else $error("status read returned non-zero upper bits");

  chk_word_in_polarity: assert property (rd_word |=>  // [RULE_08]
      hrdata_r[15:0] == ($past(sync_r.data_in) ^ {16{$past(low_true_r)}}))
    else $error("word read ignored the selected line polarity");

  chk_cfg_readback: assert property (rd_cfg |=>  // [RULE_08]
      hrdata_r == {30'h0, $past(seq_r == SEQ_LSB), $past(low_true_r)})
    else $error("configuration read does not show polarity and pending state");

  // Accesses outside the register window must reach no register at all.
  chk_unmapped_zero: assert property (a_take && !a_map |=> hrdata_r == 32'h00000000 && !dph_vld_r)
    else $error("access outside the register window was not ignored");

  // Zero wait states and an OKAY response are fixed properties of this slave.
  chk_bus_zero_wait: assert property (hreadyout && !hresp)
    else $error("slave inserted a wait state or an error response");

endmodule

// ### verif/pport_periph.sv
/*
  Peripheral model for the parallel data port: drives the data-in, aux-in
  and status lines and keeps the last word the port presented.
  Assumes the bench sets the line levels at a clock edge.
*/
`timescale 1ns/1ps

module pport_periph
  import pport_pkg::*;
(
  input  wire logic        hclk,
  input  wire line_out_t   pins_out,
  input  wire logic [15:0] word_lv,
  input  wire logic [3:0]  stat_lv,
  output line_in_t         pins_in,
  output logic [15:0]      last_rx
);
  // ---------------------------------------------------------------------------
  // Line drive
  // ---------------------------------------------------------------------------
  // Separate input lanes, so the peripheral keeps them driven at all times
  assign pins_in = {word_lv, stat_lv[1:0], stat_lv[2], stat_lv[3]};

  // Only output-direction data is taken; input-direction levels are not ours
  always_ff @(posedge hclk) begin
    if (!pins_out.dir) begin
      last_rx <= pins_out.data_out;
    end
  end
endmodule

// ### verif/test_parallel_port_data_and_aux_lines.sv
/*
  Self-checking bench for the parallel data port: AHB-Lite master tasks,
  a read-data scoreboard and pin checks. Assumes the peripheral model.
*/
`timescale 1ns/1ps
`include "pport_map.svh"

module test_parallel_port_data_and_aux_lines;
  import pport_pkg::*;
  localparam int HOLD = 2;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  line_in_t    pins_in;
  line_out_t   pins_out;
  logic [15:0] word_lv = 16'h0;
  logic [3:0]  stat_lv = 4'h0;
  logic [15:0] last_rx;
  logic [15:0] dout;
  logic [15:0] v;
  logic        rd_dp = 1'b0;
  logic [31:0] hib = 32'h0;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h801DA1E2;
  int          n_mismatch = 0;
  int          checked = 0;

  always #2.5 hclk = ~hclk;

  pport_top #(.BYTE_HOLD(HOLD)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pins_in(pins_in), .pins_out(pins_out));

  pport_periph periph (.hclk(hclk), .pins_out(pins_out), .word_lv(word_lv), .stat_lv(stat_lv),
    .pins_in(pins_in), .last_rx(last_rx));

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // The master never assumes a latency; a wait ends on hreadyout high or at this 50-edge bound
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      end_of_test();
    end
  endtask

  task automatic bus(input logic wr, input logic [5:0] idx, input logic [31:0] wd, input logic [31:0] er);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, idx, 2'h0} | hib;
    hwrite <= wr;
    if (!wr) exp_q.push_back(er);
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    rd_dp <= !wr;
    wait_rdy();
    rd_dp <= 1'b0;
  endtask

  // Pins settle one step after the edge; ends on the next edge for the driver
  task automatic pins(input logic [15:0] d, input logic dr, input logic [1:0] ax);
    #1;
    check("data_out", {16'h0, pins_out.data_out}, {16'h0, d});
    check("dir", {31'h0, pins_out.dir}, {31'h0, dr});
    check("aux_out", {30'h0, pins_out.aux_out}, {30'h0, ax});
    @(posedge hclk);
  endtask

  // ---------------------------------------------------------------------------
  // Read scoreboard
  // ---------------------------------------------------------------------------
  always @(posedge hclk) begin
    if (rd_dp && hreadyout === 1'b1) begin
      check("hresp", {31'h0, hresp}, 32'h0);
      if (exp_q.size() == 0) check("read note", 32'h1, 32'h0);
      else check("hrdata", hrdata, exp_q.pop_front());
    end
  end

  initial begin
    #100000;
    n_mismatch++;
    end_of_test();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    pins(16'h0, 1'b0, 2'h3);
    $display("reset state done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      bus(1'b1, `IDX_DATA_WORD, seed, 32'h0);
      pins(seed[15:0], 1'b0, 2'h3);
      #1;
      check("peripheral rx", {16'h0, last_rx}, {16'h0, seed[15:0]});
      @(posedge hclk);
      bus(1'b1, `IDX_DATA_BYTE, seed, 32'h0);
      pins({8'h00, seed[7:0]}, 1'b0, 2'h3);
    end
    dout = {8'h00, seed[7:0]};
    $display("output writes done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, `IDX_PCTRL, i, 32'h0);
      pins(dout, 1'b0, ~i[1:0]);
    end
    bus(1'b1, `IDX_IF_RESET, 32'hFFFFFFFF, 32'h0);
    pins(dout, 1'b0, 2'h0);
    $display("aux outputs done");
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      v = (i == 0) ? 16'h01FF : (i == 1) ? 16'hFE00 : seed[15:0];
      word_lv <= v;
      repeat (3) @(posedge hclk);
      bus(1'b0, `IDX_DATA_WORD, 32'h0, {{16{v[15]}}, v});
      bus(1'b0, `IDX_DATA_BYTE, 32'h0, {24'h0, v[7:0]});
      pins(dout, 1'b1, 2'h0);
    end
    $display("input reads done");
    for (int i = 0; i < 16; i++) begin
      stat_lv <= i[3:0];
      repeat (3) @(posedge hclk);
      bus(1'b0, `IDX_PSTATUS, 32'h0, {28'h0, i[2], ~i[3], ~i[1], ~i[0]});
    end
    hib = 32'h00000100;
    bus(1'b0, `IDX_PSTATUS, 32'h0, 32'h0);
    hib = 32'h0;
    $display("status reads done");
    bus(1'b1, `IDX_CONFIG, 32'h1, 32'h0);
    bus(1'b0, `IDX_CONFIG, 32'h0, 32'h1);
    seed = lfsr(seed);
    bus(1'b1, `IDX_DATA_WORD, seed, 32'h0);
    pins(~seed[15:0], 1'b0, 2'h0);
    word_lv <= seed[31:16];
    repeat (3) @(posedge hclk);
    bus(1'b0, `IDX_DATA_WORD, 32'h0, {{16{~seed[31]}}, ~seed[31:16]});
    bus(1'b1, `IDX_IF_RESET, 32'h0, 32'h0);
    bus(1'b0, `IDX_CONFIG, 32'h0, 32'h0);
    $display("polarity done");
    seed = lfsr(seed);
    bus(1'b1, `IDX_BYTE_SEQ, seed, 32'h0);
    pins({8'h00, seed[15:8]}, 1'b0, 2'h0);
    bus(1'b0, `IDX_CONFIG, 32'h0, 32'h2);
    pins({8'h00, seed[7:0]}, 1'b0, 2'h0);
    seed = lfsr(seed);
    bus(1'b1, `IDX_BYTE_SEQ, seed, 32'h0);
    bus(1'b1, `IDX_DATA_BYTE, {16'h0, seed[31:16]}, 32'h0);
    repeat (3) @(posedge hclk);
    pins({8'h00, seed[23:16]}, 1'b0, 2'h0);
    bus(1'b0, `IDX_CONFIG, 32'h0, 32'h0);
    $display("byte sequence done");
    repeat (2) @(posedge hclk);
    check("read notes left", exp_q.size(), 32'h0);
    end_of_test();
  end
endmodule
